// ==== sim/tb.sv ====
// Self-checking testbench for the clock, key and clock-calendar access block
module tb import pckra_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic por_i = 1'b1;
	logic [7:0] sfr_addr_i = 8'h00;
	logic [7:0] sfr_wdata_i = 8'h00;
	logic sfr_wr_i = 1'b0;
	logic sfr_rd_i = 1'b0;
	logic [7:0] sfr_rdata_o;
	logic pll_lock_i = 1'b1;
	logic xtal_tick_i = 1'b0;
	logic battery_save_mode_i = 1'b0;
	logic [7:0] temp_comp_i = 8'h5c;
	logic sys_clk_ok_o, core_tick_o, meter_tick_o, metering_shutdown_o;
	logic core_shutdown_o, mcu_reset_o, lock_fault_flag_o;
	int errors = 0;
	int checks_done = 0;
	logic [7:0] rd, rd2;
	int n;

	always #5 core_clk_i = ~core_clk_i;

	pckra_top u_pckra_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .por_i(por_i),
		.sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
		.sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .pll_lock_i(pll_lock_i),
		.xtal_tick_i(xtal_tick_i), .battery_save_mode_i(battery_save_mode_i),
		.temp_comp_i(temp_comp_i), .sys_clk_ok_o(sys_clk_ok_o), .core_tick_o(core_tick_o),
		.meter_tick_o(meter_tick_o), .metering_shutdown_o(metering_shutdown_o),
		.core_shutdown_o(core_shutdown_o), .mcu_reset_o(mcu_reset_o),
		.lock_fault_flag_o(lock_fault_flag_o));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		sfr_wr_i <= 1'b1;
		@(posedge core_clk_i);
		sfr_wr_i <= 1'b0;
	endtask

	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		sfr_addr_i <= a;
		sfr_rd_i <= 1'b1;
		@(posedge core_clk_i);
		sfr_rd_i <= 1'b0;
		@(posedge core_clk_i);
		#1 d = sfr_rdata_o;
	endtask

	task automatic rtc_wr(input logic [7:0] a, input logic [7:0] d);
		sfr_write(SFR_UNLOCK_KEY, KEY_RTC);
		sfr_write(SFR_RTC_POINTER_DATA, d);
		sfr_write(SFR_RTC_POINTER, 8'h80 | a);
	endtask

	task automatic rtc_rd(input logic [7:0] a, output logic [7:0] d);
		sfr_write(SFR_RTC_POINTER, a);
		sfr_read(SFR_RTC_POINTER_DATA, d);
	endtask

	task automatic cycles(input int k);
		repeat (k) @(posedge core_clk_i);
		#1;
	endtask

	// Cycles between two ticks of the core (sel 0) or metering (sel 1) enable
	task automatic period(input bit sel, output int p);
		int k;
		k = 0;
		do begin
			@(posedge core_clk_i);
			#1 k++;
		end while ((sel ? meter_tick_o : core_tick_o) !== 1'b1 && k < 300);
		p = 0;
		do begin
			@(posedge core_clk_i);
			#1 p++;
		end while ((sel ? meter_tick_o : core_tick_o) !== 1'b1 && p < 300);
	endtask

	task automatic xtal(input int k);
		repeat (k) begin
			@(posedge core_clk_i);
			xtal_tick_i <= 1'b1;
			@(posedge core_clk_i);
			xtal_tick_i <= 1'b0;
		end
	endtask

	task automatic power_set(input logic [7:0] v);
		sfr_write(SFR_UNLOCK_KEY, KEY_POWER);
		sfr_write(SFR_POWER_CONTROL, v);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		sfr_read(SFR_POWER_CONTROL, rd);
		chk(rd, POWER_RESET);
		sfr_read(SFR_UNLOCK_KEY, rd);
		chk(rd, KEY_RESET);
		period(1'b0, n);
		chk(n[7:0], 8'h04);
		period(1'b1, n);
		chk(n[7:0], 8'h05);
		chk({7'h00, sys_clk_ok_o}, 8'h01);
		$display("test reset done");
	endtask

	task automatic t_power;
		battery_save_mode_i <= 1'b1;
		power_set(8'h53);
		sfr_read(SFR_POWER_CONTROL, rd);
		chk(rd, 8'hd3);
		chk({7'h00, metering_shutdown_o}, 8'h01);
		chk({7'h00, core_shutdown_o}, 8'h01);
		period(1'b0, n);
		chk(n[7:0], 8'h08);
		battery_save_mode_i <= 1'b0;
		cycles(3);
		chk({7'h00, core_shutdown_o}, 8'h00);
		power_set(8'h07);
		cycles(3);
		chk({7'h00, metering_shutdown_o}, 8'h00);
		period(1'b0, n);
		chk(n[7:0], 8'h80);
		period(1'b1, n);
		chk(n[7:0], 8'h05);
		power_set(8'h02);
		$display("test power done");
	endtask

	task automatic t_key_miss;
		sfr_write(SFR_UNLOCK_KEY, KEY_POWER);
		sfr_write(SFR_RTC_NOMINAL_COMP, 8'h00);
		sfr_write(SFR_POWER_CONTROL, 8'h45);
		sfr_write(SFR_POWER_CONTROL, 8'h41);
		sfr_read(SFR_POWER_CONTROL, rd);
		chk(rd, POWER_RESET);
		$display("test key miss done");
	endtask

	task automatic t_rtc_access;
		rtc_wr(8'h10, 8'h11);
		sfr_read(SFR_UNLOCK_KEY, rd);
		chk(rd, KEY_RESET);
		rtc_rd(8'h10, rd);
		chk(rd, 8'h11);
		sfr_write(SFR_RTC_POINTER_DATA, 8'h3c);
		sfr_write(SFR_RTC_POINTER, 8'h90);
		rtc_rd(8'h10, rd);
		chk(rd, 8'h11);
		sfr_write(SFR_RTC_POINTER, 8'h88);
		rtc_rd(8'h08, rd);
		chk(rd, 8'h00);
		rtc_wr(8'h11, 8'h22);
		rtc_rd(8'h11, rd);
		chk(rd, 8'h22);
		rtc_rd(8'h10, rd);
		chk(rd, 8'h11);
		$display("test rtc access done");
	endtask

	task automatic t_rtc_time;
		battery_save_mode_i <= 1'b1;
		power_set(8'h12);
		rtc_wr({3'h0, RTC_HUNDREDTHS}, 8'h05);
		sfr_write(SFR_RTC_CONFIG, 8'hff);
		sfr_write(SFR_RTC_CONFIG_TWO, 8'hff);
		xtal(512);
		rtc_rd({3'h0, RTC_HUNDREDTHS}, rd);
		chk(rd, 8'h07);
		sfr_read(SFR_RTC_CONFIG, rd);
		chk(rd, RTC_CONFIG_MASK);
		sfr_read(SFR_RTC_CONFIG_TWO, rd);
		chk(rd, RTC_CONFIG_TWO_MASK);
		rtc_rd({3'h0, RTC_HUNDREDTHS}, rd);
		rtc_rd(8'h02, rd2);
		rtc_rd({3'h0, RTC_HUNDREDTHS}, rd2);
		chk(rd2, rd);
		battery_save_mode_i <= 1'b0;
		power_set(8'h02);
		$display("test rtc time done");
	endtask

	task automatic t_lock;
		@(posedge core_clk_i);
		pll_lock_i <= 1'b0;
		cycles(1);
		chk({6'h00, mcu_reset_o, lock_fault_flag_o}, 8'h03);
		chk({7'h00, sys_clk_ok_o}, 8'h00);
		cycles(1);
		chk({6'h00, mcu_reset_o, lock_fault_flag_o}, 8'h01);
		pll_lock_i <= 1'b1;
		rst_i <= 1'b1;
		cycles(3);
		rst_i <= 1'b0;
		chk({7'h00, lock_fault_flag_o}, 8'h01);
		rtc_rd({3'h0, RTC_HUNDREDTHS}, rd);
		chk(rd, 8'h07);
		sfr_write(SFR_ADC_START_REG, 8'h80);
		cycles(2);
		chk({7'h00, lock_fault_flag_o}, 8'h00);
		por_i <= 1'b1;
		cycles(3);
		por_i <= 1'b0;
		rtc_rd({3'h0, RTC_HUNDREDTHS}, rd);
		chk(rd, 8'h00);
		$display("test lock done");
	endtask

	task automatic t_readonly;
		sfr_write(SFR_RTC_TEMP_COMP, 8'ha3);
		sfr_read(SFR_RTC_TEMP_COMP, rd);
		chk(rd, 8'h5c);
		sfr_write(SFR_RTC_NOMINAL_COMP, 8'h3c);
		sfr_read(SFR_RTC_NOMINAL_COMP, rd);
		chk(rd, 8'h3c);
		sfr_read(8'h90, rd);
		chk(rd, 8'h00);
		$display("test read only done");
	endtask

	// ----------------------------------------
	// Sequence, watchdog and verdict
	// ----------------------------------------
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#200000;
		errors++;
		report_and_stop();
	end

	initial begin
		repeat (10) @(posedge core_clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		t_reset();
		t_power();
		t_key_miss();
		t_rtc_access();
		t_rtc_time();
		t_lock();
		t_readonly();
		report_and_stop();
	end
endmodule

// ==== verilog/pckra_clk_div.sv ====
// Core clock and metering clock enable dividers
module pckra_clk_div
	import pckra_pkg::*;
#(
	parameter int CNT_W = 7
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Control
	input wire logic [CD_WIDTH-1:0] cd_i,
	// Ticks
	output logic core_tick_o,
	output logic meter_tick_o
);
	logic [CNT_W-1:0] core_cnt;
	logic [CNT_W-1:0] core_mask;
	logic [2:0] meter_cnt;

	assign core_mask = CNT_W'((1 << cd_i) - 1);

	// ----------------------------------------
	// Core divider
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			core_cnt <= '0;
			core_tick_o <= 1'b0;
		end else begin
			core_cnt <= core_cnt + 1'b1;
			core_tick_o <= ((core_cnt & core_mask) == core_mask);
		end
	end

	// ----------------------------------------
	// Metering divider
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			meter_cnt <= '0;
			meter_tick_o <= 1'b0;
		end else begin
			meter_cnt <= (meter_cnt == 3'(METER_DIVIDE - 1)) ? 3'h0 : meter_cnt + 3'h1;
			meter_tick_o <= (meter_cnt == 3'(METER_DIVIDE - 1));
		end
	end

	meter_ratio_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		meter_tick_o |=> !meter_tick_o [*4] ##1 meter_tick_o)
		else $error("Metering tick not one in five");
endmodule

// ==== verilog/pckra_pkg.sv ====
// Constants shared by the clock, key and clock-calendar access block
package pckra_pkg;
	// ----------------------------------------
	// Special-function register addresses
	// ----------------------------------------
	localparam logic [7:0] SFR_RTC_CONFIG = 8'ha1;
	localparam logic [7:0] SFR_RTC_CONFIG_TWO = 8'ha2;
	localparam logic [7:0] SFR_RTC_POINTER = 8'ha3;
	localparam logic [7:0] SFR_RTC_POINTER_DATA = 8'ha4;
	localparam logic [7:0] SFR_UNLOCK_KEY = 8'hc1;
	localparam logic [7:0] SFR_POWER_CONTROL = 8'hc5;
	localparam logic [7:0] SFR_ADC_START_REG = 8'hd8;
	localparam logic [7:0] SFR_RTC_NOMINAL_COMP = 8'hf6;
	localparam logic [7:0] SFR_RTC_TEMP_COMP = 8'hf7;
	// ----------------------------------------
	// Keys, reset values and field layout
	// ----------------------------------------
	localparam logic [7:0] KEY_POWER = 8'ha7;
	localparam logic [7:0] KEY_RTC = 8'hea;
	localparam logic [7:0] KEY_RESET = 8'h00;
	localparam logic [7:0] POWER_RESET = 8'h82;
	localparam logic [7:0] POWER_FIXED_ONE = 8'h80;
	localparam logic [7:0] POWER_WRITE_MASK = 8'h7f;
	localparam logic [7:0] RTC_CONFIG_MASK = 8'h7e;
	localparam logic [7:0] RTC_CONFIG_TWO_MASK = 8'h1f;
	localparam int POWER_METER_BIT = 6;
	localparam int POWER_CORE_BIT = 4;
	localparam int CD_WIDTH = 3;
	localparam int POINTER_WRITE_BIT = 7;
	localparam int ACK_BIT = 7;
	// ----------------------------------------
	// Clock-calendar internal addresses
	// ----------------------------------------
	localparam int RTC_AW = 5;
	localparam logic [4:0] RTC_HUNDREDTHS = 5'h01;
	localparam logic [4:0] RTC_YEAR = 5'h08;
	localparam logic [4:0] RTC_INTERVAL = 5'h09;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int XTAL_HZ = 32768;
	localparam int SLOW_HZ = 128;
	localparam int XTAL_PER_SLOW = XTAL_HZ / SLOW_HZ;
	localparam int METER_DIVIDE = 5;
endpackage

// ==== verilog/pckra_rtc_mem.sv ====
// Clock-calendar indirect register store with registered read
module pckra_rtc_mem #(
	parameter int AW = 5,
	parameter int DW = 8
) (
	// Clock
	input wire logic core_clk_i,
	// Write port
	input wire logic wr_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	// Read port
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge core_clk_i) begin
		if (wr_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule

// ==== verilog/pckra_top.sv ====
// Key-protected clock, power control and clock-calendar pointer writes
module pckra_top
	import pckra_pkg::*;
(
	// Clock and resets
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	// Special-function register port
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	output logic [7:0] sfr_rdata_o,
	// PLL, crystal, mode and temperature compensation
	input wire logic pll_lock_i,
	input wire logic xtal_tick_i,
	input wire logic battery_save_mode_i,
	input wire logic [7:0] temp_comp_i,
	// Clock and power outputs
	output logic sys_clk_ok_o,
	output logic core_tick_o,
	output logic meter_tick_o,
	output logic metering_shutdown_o,
	output logic core_shutdown_o,
	output logic mcu_reset_o,
	output logic lock_fault_flag_o
);
	logic [7:0] unlock_key;
	logic key_fresh;
	logic [7:0] power_control;
	logic [7:0] rtc_config;
	logic [7:0] rtc_config_two;
	logic [7:0] cfg_pend;
	logic [7:0] cfg_two_pend;
	logic cfg_pv;
	logic cfg_two_pv;
	logic [7:0] iv_pend;
	logic iv_pv;
	logic [7:0] rtc_pointer;
	logic [7:0] rtc_pointer_data;
	logic [7:0] rtc_nominal_comp;
	logic [7:0] rtc_temp_comp;
	logic rd_pend;
	logic [7:0] tk [1:8];
	logic [8:1] tk_en;
	logic [7:0] prescale;
	logic slow_tick;
	logic lock_q;
	logic lock_loss;
	logic wr_key;
	logic wr_pow;
	logic pow_ok;
	logic wr_ptr;
	logic ind_wr;
	logic ack_wr;
	logic [4:0] ind_addr;
	logic mem_wr;
	logic [7:0] mem_rdata;
	logic [7:0] next_rdata;

	// ----------------------------------------
	// Calendar limits
	// ----------------------------------------
	function automatic logic [7:0] tk_max(input int i);
		case (i)
			1: tk_max = 8'h7f;
			2, 3: tk_max = 8'h3b;
			4: tk_max = 8'h17;
			5: tk_max = 8'h06;
			6: tk_max = 8'h1f;
			7: tk_max = 8'h0c;
			default: tk_max = 8'h63;
		endcase
	endfunction

	function automatic logic [7:0] tk_min(input int i);
		tk_min = (i == 6 || i == 7) ? 8'h01 : 8'h00;
	endfunction

	function automatic logic is_counter(input logic [4:0] a);
		is_counter = (a >= RTC_HUNDREDTHS) && (a <= RTC_YEAR);
	endfunction

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign wr_key = sfr_wr_i && (sfr_addr_i == SFR_UNLOCK_KEY);
	assign wr_pow = sfr_wr_i && (sfr_addr_i == SFR_POWER_CONTROL);
	assign pow_ok = wr_pow && key_fresh && (unlock_key == KEY_POWER);
	assign wr_ptr = sfr_wr_i && (sfr_addr_i == SFR_RTC_POINTER);
	assign ind_wr = wr_ptr && sfr_wdata_i[POINTER_WRITE_BIT] && (unlock_key == KEY_RTC);
	assign ind_addr = sfr_wdata_i[4:0];
	assign ack_wr = sfr_wr_i && (sfr_addr_i == SFR_ADC_START_REG) && sfr_wdata_i[ACK_BIT];
	assign lock_loss = lock_q && !pll_lock_i;
	assign mem_wr = ind_wr && !is_counter(ind_addr) && (ind_addr != RTC_INTERVAL);

	// ----------------------------------------
	// Key register
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i || por_i) begin
			unlock_key <= KEY_RESET;
			key_fresh <= 1'b0;
		end else begin
			key_fresh <= wr_key || (key_fresh && !sfr_wr_i);
			if (wr_key) begin
				unlock_key <= sfr_wdata_i;
			end else if (ind_wr) begin
				unlock_key <= KEY_RESET;
			end
		end
	end

	// ----------------------------------------
	// Power control
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i || por_i) begin
			power_control <= POWER_RESET;
		end else if (pow_ok) begin
			power_control <= (sfr_wdata_i & POWER_WRITE_MASK) | POWER_FIXED_ONE;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i || por_i) begin
			metering_shutdown_o <= 1'b0;
			core_shutdown_o <= 1'b0;
			sys_clk_ok_o <= 1'b0;
		end else begin
			metering_shutdown_o <= power_control[POWER_METER_BIT];
			core_shutdown_o <= power_control[POWER_CORE_BIT] && battery_save_mode_i;
			sys_clk_ok_o <= pll_lock_i;
		end
	end

	pckra_clk_div u_div (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i || por_i),
		.cd_i(power_control[CD_WIDTH-1:0]),
		.core_tick_o(core_tick_o),
		.meter_tick_o(meter_tick_o)
	);

	// ----------------------------------------
	// Lock fault
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (por_i) begin
			lock_q <= 1'b0;
			lock_fault_flag_o <= 1'b0;
			mcu_reset_o <= 1'b0;
		end else begin
			lock_q <= pll_lock_i;
			mcu_reset_o <= lock_loss;
			if (lock_loss) begin
				lock_fault_flag_o <= 1'b1;
			end else if (ack_wr) begin
				lock_fault_flag_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Calendar counters
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (por_i) begin
			prescale <= '0;
			slow_tick <= 1'b0;
		end else begin
			slow_tick <= 1'b0;
			if (xtal_tick_i) begin
				prescale <= prescale + 8'h01;
				slow_tick <= (prescale == 8'(XTAL_PER_SLOW - 1));
			end
		end
	end

	always_comb begin
		tk_en[1] = slow_tick;
		tk_en[2] = tk_en[1] && (tk[1] == tk_max(1));
		tk_en[3] = tk_en[2] && (tk[2] == tk_max(2));
		tk_en[4] = tk_en[3] && (tk[3] == tk_max(3));
		tk_en[5] = tk_en[4] && (tk[4] == tk_max(4));
		tk_en[6] = tk_en[5];
		tk_en[7] = tk_en[6] && (tk[6] == tk_max(6));
		tk_en[8] = tk_en[7] && (tk[7] == tk_max(7));
	end

	always_ff @(posedge core_clk_i) begin
		if (por_i) begin
			for (int i = 1; i <= 8; i++) begin
				tk[i] <= tk_min(i);
			end
		end else begin
			for (int i = 1; i <= 8; i++) begin
				if (ind_wr && ind_addr == 5'(i)) begin
					tk[i] <= rtc_pointer_data;
				end else if (tk_en[i]) begin
					tk[i] <= (tk[i] >= tk_max(i)) ? tk_min(i) : tk[i] + 8'h01;
				end
			end
		end
	end

	// ----------------------------------------
	// Slow-updated configuration
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i || por_i) begin
			rtc_config <= '0;
			rtc_config_two <= '0;
			cfg_pend <= '0;
			cfg_two_pend <= '0;
			cfg_pv <= 1'b0;
			cfg_two_pv <= 1'b0;
			iv_pend <= '0;
			iv_pv <= 1'b0;
		end else begin
			if (slow_tick && cfg_pv) begin
				rtc_config <= cfg_pend;
				cfg_pv <= 1'b0;
			end
			if (slow_tick && cfg_two_pv) begin
				rtc_config_two <= cfg_two_pend;
				cfg_two_pv <= 1'b0;
			end
			if (slow_tick && iv_pv && !mem_wr) begin
				iv_pv <= 1'b0;
			end
			if (sfr_wr_i && sfr_addr_i == SFR_RTC_CONFIG) begin
				cfg_pend <= sfr_wdata_i & RTC_CONFIG_MASK;
				cfg_pv <= 1'b1;
			end
			if (sfr_wr_i && sfr_addr_i == SFR_RTC_CONFIG_TWO) begin
				cfg_two_pend <= sfr_wdata_i & RTC_CONFIG_TWO_MASK;
				cfg_two_pv <= 1'b1;
			end
			if (ind_wr && ind_addr == RTC_INTERVAL) begin
				iv_pend <= rtc_pointer_data;
				iv_pv <= 1'b1;
			end
		end
	end

	pckra_rtc_mem #(
		.AW(RTC_AW),
		.DW(8)
	) u_mem (
		.core_clk_i(core_clk_i),
		.wr_i(mem_wr || (slow_tick && iv_pv)),
		.waddr_i(mem_wr ? ind_addr : RTC_INTERVAL),
		.wdata_i(mem_wr ? rtc_pointer_data : iv_pend),
		.raddr_i(wr_ptr ? ind_addr : rtc_pointer[4:0]),
		.rdata_o(mem_rdata)
	);

	// ----------------------------------------
	// Pointer, data and compensation
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i || por_i) begin
			rtc_pointer <= '0;
			rtc_pointer_data <= '0;
			rtc_nominal_comp <= '0;
			rtc_temp_comp <= '0;
			rd_pend <= 1'b0;
		end else begin
			rtc_temp_comp <= temp_comp_i;
			rd_pend <= wr_ptr && !sfr_wdata_i[POINTER_WRITE_BIT];
			if (wr_ptr) begin
				rtc_pointer <= sfr_wdata_i;
			end
			if (rd_pend) begin
				rtc_pointer_data <= is_counter(rtc_pointer[4:0]) ? tk[rtc_pointer[3:0]] : mem_rdata;
			end
			if (sfr_wr_i && sfr_addr_i == SFR_RTC_POINTER_DATA) begin
				rtc_pointer_data <= sfr_wdata_i;
			end
			if (sfr_wr_i && sfr_addr_i == SFR_RTC_NOMINAL_COMP) begin
				rtc_nominal_comp <= sfr_wdata_i;
			end
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		case (sfr_addr_i)
			SFR_RTC_CONFIG: next_rdata = rtc_config;
			SFR_RTC_CONFIG_TWO: next_rdata = rtc_config_two;
			SFR_RTC_POINTER: next_rdata = rtc_pointer;
			SFR_RTC_POINTER_DATA: next_rdata = rtc_pointer_data;
			SFR_UNLOCK_KEY: next_rdata = unlock_key;
			SFR_POWER_CONTROL: next_rdata = power_control;
			SFR_RTC_NOMINAL_COMP: next_rdata = rtc_nominal_comp;
			SFR_RTC_TEMP_COMP: next_rdata = rtc_temp_comp;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i || por_i) begin
			sfr_rdata_o <= '0;
		end else if (sfr_rd_i) begin
			sfr_rdata_o <= next_rdata;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	pow_locked_a: assert property (@(posedge core_clk_i) disable iff (rst_i || por_i)
		(wr_pow && !(key_fresh && unlock_key == KEY_POWER)) |=> $stable(power_control))
		else $error("Power control changed without key");

	pow_unlock_a: assert property (@(posedge core_clk_i) disable iff (rst_i || por_i)
		(wr_key && sfr_wdata_i == KEY_POWER) ##1 !sfr_wr_i ##1 wr_pow
		|=> power_control == (($past(sfr_wdata_i) & POWER_WRITE_MASK) | POWER_FIXED_ONE))
		else $error("Unlocked power write not stored");

	fault_set_a: assert property (@(posedge core_clk_i) disable iff (por_i)
		(lock_q && !pll_lock_i) |=> (lock_fault_flag_o && mcu_reset_o))
		else $error("Lock loss did not flag and reset");

	fault_ack_a: assert property (@(posedge core_clk_i) disable iff (por_i)
		(ack_wr && !lock_loss) |=> !lock_fault_flag_o)
		else $error("Acknowledge did not clear fault");

	key_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i || por_i)
		(ind_wr && is_counter(ind_addr)) |=> (unlock_key == KEY_RESET))
		else $error("Key not cleared after calendar write");

	year_refuse_a: assert property (@(posedge core_clk_i) disable iff (rst_i || por_i)
		(wr_ptr && sfr_wdata_i[7] && sfr_wdata_i[4:0] == RTC_YEAR && unlock_key != KEY_RTC
		&& !tk_en[8]) |=> $stable(tk[8]))
		else $error("Calendar written without key");

	cfg_apply_a: assert property (@(posedge core_clk_i) disable iff (rst_i || por_i)
		(slow_tick && cfg_pv && !(sfr_wr_i && sfr_addr_i == SFR_RTC_CONFIG))
		|=> (!cfg_pv && rtc_config == $past(cfg_pend)))
		else $error("Configuration not applied on slow tick");

	core_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i || por_i)
		(power_control[POWER_CORE_BIT] && battery_save_mode_i) |=> core_shutdown_o)
		else $error("Core not shut down in battery save mode");
endmodule
